// *** design/pic_top.sv ***
// Prioritised interrupt controller: pin sensing, priority registers, arbitration and CPU hand-off.
// Assumes one clock, a CPU that reports its mask level and pulses an accept on the same clock,
// and peripheral request levels generated on that clock.
module pic_top (
	input  wire logic                              sys_clk,
	input  wire logic                              srst,
	input  wire logic                              ce,
	input  wire pic_pkg::pic_ahb_in_s              ahb_in,
	output      pic_pkg::pic_ahb_out_s             ahb_out,
	input  wire logic [pic_pkg::PIC_EXT_N-1:0]     ext_request_pins,
	input  wire logic                              nmi_pin,
	input  wire logic [pic_pkg::PIC_PER_N-1:0]     periph_req,
	input  wire logic [pic_pkg::PIC_LVL_W-1:0]     cpu_mask_level,
	input  wire logic                              cpu_accept,
	output      pic_pkg::pic_cpu_out_s             cpu_out
);
	import pic_pkg::*;

	// ---------------------------------------------------------------------
	// State and combinational helpers
	// ---------------------------------------------------------------------
	pic_state_s                 s;
	pic_state_s                 next_s;
	logic                       armed;
	logic                       accept_now;
	logic                       nmi_ack;
	logic [PIC_EXT_N-1:0]       wr_clr;
	logic [PIC_EXT_N-1:0]       ack_clr;
	logic [PIC_EXT_N-1:0]       pin_rise;
	logic [PIC_EXT_N-1:0]       pin_fall;
	logic [PIC_EXT_N-1:0]       pin_ev;
	logic                       nmi_rise;
	logic                       nmi_fall;
	logic [1:0]                 sense;
	logic [PIC_SRC_N-1:0]       req_all;
	logic                       found;
	logic [PIC_LVL_W-1:0]       best_lvl;
	logic [PIC_VEC_W-1:0]       best_vec;
	logic [PIC_SRC_W-1:0]       best_src;
	logic [31:0]                rdata;
	logic [7:0]                 rd_ofs;
	logic                       take;

	assign ahb_out = s.ahb;
	assign cpu_out = s.cpu;

	always_comb begin
		next_s = s;
		next_s.cpu.mask_load = 1'b0;
		wr_clr = '0;
		ack_clr = '0;
		nmi_ack = 1'b0;
		pin_ev = '0;
		sense = PIC_SENSE_LOW;
		rdata = 32'h0;
		found = 1'b0;
		best_lvl = PIC_LVL_OFF;
		best_vec = '1;
		best_src = '0;

		// -----------------------------------------------------------------
		// Pin synchronisers
		// -----------------------------------------------------------------
		// The third stage guards against a single-cycle glitch: a new level is taken
		// only once two successive samples agree.
		next_s.pin_s1 = ext_request_pins;                  // [RL22]
		next_s.pin_s2 = s.pin_s1;
		next_s.pin_s3 = s.pin_s2;
		next_s.nmi_s1 = nmi_pin;                           // [RL22]
		next_s.nmi_s2 = s.nmi_s1;
		next_s.nmi_s3 = s.nmi_s2;
		for (int i = 0; i < PIC_EXT_N; i++) begin
			if (s.pin_s2[i] == s.pin_s3[i]) begin
				next_s.pin_f[i] = s.pin_s3[i];             // [RL22]
			end
		end
		if (s.nmi_s2 == s.nmi_s3) begin
			next_s.nmi_f = s.nmi_s3;                       // [RL22]
		end
		// Edges are ignored until the pipeline holds real pin samples, so the reset
		// value of the filter never looks like a transition.
		armed = (s.warm == PIC_WARM_DONE);
		if (!armed) begin
			next_s.warm = s.warm + 3'h1;
		end
		pin_rise = armed ? (~s.pin_f & next_s.pin_f) : '0;
		pin_fall = armed ? (s.pin_f & ~next_s.pin_f) : '0;
		nmi_rise = armed & ~s.nmi_f & next_s.nmi_f;
		nmi_fall = armed & s.nmi_f & ~next_s.nmi_f;

		// -----------------------------------------------------------------
		// AHB-Lite slave: data phase of a write
		// -----------------------------------------------------------------
		// Writes complete with no wait state; a write whose address phase was not a
		// full word is dropped, which keeps partial priority fields impossible.
		next_s.ahb.hreadyout = 1'b1;
		next_s.ahb.hresp = PIC_HRESP_OKAY;
		next_s.wr_pend = 1'b0;
		if (s.wr_pend) begin
			if (s.wr_ofs <= PIC_OFS_PRIO_E) begin
				for (int j = 0; j < PIC_SRC_N; j++) begin
					if (j / PIC_FLD_N == int'(s.wr_ofs[4:2])) begin
						// Field 0 of a register sits in its top nibble.
						next_s.prio[j] = ahb_in.hwdata[(PIC_FLD_N - 1 - j % PIC_FLD_N) * PIC_LVL_W +: PIC_LVL_W]; // [RL17] [RL13] [RL14]
					end
				end
			end else if (s.wr_ofs == PIC_OFS_CTRL0) begin
				next_s.nmi_edge_select = ahb_in.hwdata[PIC_NMI_EDGE_BIT];                      // [RL4]
			end else if (s.wr_ofs == PIC_OFS_SENSE) begin
				next_s.sense_hi = ahb_in.hwdata[PIC_HI_LSB +: PIC_EXT_N];                      // [RL6]
				next_s.sense_lo = ahb_in.hwdata[PIC_EXT_N-1:0];                                // [RL6]
			end else if (s.wr_ofs == PIC_OFS_STATUS) begin
				// Only flags that were read as one may be withdrawn by writing zero.
				wr_clr = s.seen & ~ahb_in.hwdata[PIC_EXT_N-1:0];                              // [RL11]
				next_s.seen = '0;
			end
		end

		// -----------------------------------------------------------------
		// AHB-Lite slave: address phase
		// -----------------------------------------------------------------
		take = ahb_in.hsel & ahb_in.htrans[1] & ahb_in.hready;
		rd_ofs = ahb_in.haddr[7:0];
		if (rd_ofs <= PIC_OFS_PRIO_E) begin
			for (int j = 0; j < PIC_SRC_N; j++) begin
				if (j / PIC_FLD_N == int'(rd_ofs[4:2])) begin
					rdata[(PIC_FLD_N - 1 - j % PIC_FLD_N) * PIC_LVL_W +: PIC_LVL_W] = s.prio[j]; // [RL17]
				end
			end
		end else if (rd_ofs == PIC_OFS_CTRL0) begin
			rdata[PIC_NMI_EDGE_BIT] = s.nmi_edge_select;
			rdata[PIC_NMI_LVL_BIT] = s.nmi_f;
		end else if (rd_ofs == PIC_OFS_SENSE) begin
			rdata[PIC_HI_LSB +: PIC_EXT_N] = s.sense_hi;
			rdata[PIC_EXT_N-1:0] = s.sense_lo;
		end else if (rd_ofs == PIC_OFS_STATUS) begin
			rdata[PIC_EXT_N-1:0] = s.flag;                 // [RL8]
			rdata[PIC_PINLV_LSB +: PIC_EXT_N] = s.pin_f;
		end
		if (take) begin
			if (ahb_in.hwrite) begin
				next_s.wr_pend = (ahb_in.hsize == PIC_HSIZE_WORD);
				next_s.wr_ofs = rd_ofs;
			end else begin
				next_s.ahb.hrdata = rdata;
				if (rd_ofs == PIC_OFS_STATUS) begin
					next_s.seen = s.seen | s.flag;         // [RL11]
				end
			end
		end

		// -----------------------------------------------------------------
		// Acceptance by the CPU
		// -----------------------------------------------------------------
		// The accept applies to the request that is on the outputs in this cycle; the
		// mask to load is the level that was presented with it.
		accept_now = cpu_accept & s.cpu.irq;
		if (accept_now) begin
			next_s.cpu.mask_load = 1'b1;
			next_s.cpu.mask_level = s.cpu.irq_level;       // [RL5] [RL12] [RL15]
			if (s.cpu.irq_nmi) begin
				nmi_ack = 1'b1;
			end else if (int'(s.cur_src) < PIC_EXT_N) begin
				ack_clr[s.cur_src[2:0]] = 1'b1;            // [RL21]
			end
		end

		// -----------------------------------------------------------------
		// Request detection
		// -----------------------------------------------------------------
		for (int i = 0; i < PIC_EXT_N; i++) begin
			sense = {s.sense_hi[i], s.sense_lo[i]};
			case (sense)
				PIC_SENSE_LOW: pin_ev[i] = 1'b0;
				PIC_SENSE_FAL: pin_ev[i] = pin_fall[i];    // [RL9]
				PIC_SENSE_RIS: pin_ev[i] = pin_rise[i];    // [RL9]
				default:       pin_ev[i] = pin_rise[i] | pin_fall[i]; // [RL9]
			endcase
			if (sense == PIC_SENSE_LOW) begin
				next_s.flag[i] = ~next_s.pin_f[i];         // [RL7]
			end else begin
				// A new edge in the clearing cycle keeps the flag set.
				next_s.flag[i] = pin_ev[i] | (s.flag[i] & ~wr_clr[i] & ~ack_clr[i]); // [RL10] [RL11] [RL21]
			end
		end
		next_s.nmi_pend = (s.nmi_edge_select ? nmi_rise : nmi_fall) | (s.nmi_pend & ~nmi_ack); // [RL4]

		// -----------------------------------------------------------------
		// Arbitration
		// -----------------------------------------------------------------
		req_all = {periph_req, s.flag};
		for (int j = 0; j < PIC_SRC_N; j++) begin
			if (req_all[j] && s.prio[j] != PIC_LVL_OFF) begin                                 // [RL2]
				if (s.prio[j] > best_lvl || (s.prio[j] == best_lvl && PIC_SRC_VEC[j] < best_vec)) begin // [RL1] [RL19]
					found = 1'b1;
					best_lvl = s.prio[j];
					best_vec = PIC_SRC_VEC[j];
					best_src = PIC_SRC_W'(j);
				end
			end
		end
		next_s.cpu.irq = 1'b0;
		next_s.cpu.irq_nmi = 1'b0;
		if (next_s.nmi_pend) begin
			// Level 15 is presented ahead of every programmable source and is not masked.
			next_s.cpu.irq = 1'b1;                         // [RL3]
			next_s.cpu.irq_nmi = 1'b1;
			next_s.cpu.irq_level = PIC_LVL_TOP;            // [RL5]
			next_s.cpu.irq_vector = PIC_NMI_VEC;           // [RL16]
		end else if (found && best_lvl > cpu_mask_level) begin
			next_s.cpu.irq = 1'b1;                         // [RL18]
			next_s.cpu.irq_level = best_lvl;               // [RL12] [RL15]
			next_s.cpu.irq_vector = best_vec;              // [RL16]
			next_s.cur_src = best_src;
		end
		// The request drops for one cycle after an accept so the CPU never sees the
		// source it has just taken, whose flag clears only at this edge.
		if (accept_now) begin
			next_s.cpu.irq = 1'b0;
		end
	end

	// ---------------------------------------------------------------------
	// State register
	// ---------------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s <= PIC_STATE_RST;                            // [RL20]
		end else if (ce) begin
			s <= next_s;
		end
	end
endmodule

// *** design/pic_pkg.sv ***
// Constants, carrier structs and state layout of the prioritised interrupt controller.
// Assumes a single 100 MHz clock domain and a word-only AHB-Lite register port.
//
// Behaviour
// (RL1) A four-bit priority field is unsigned: 0000 is level 0, 1111 is level 15.
// (RL2) A maskable source whose priority is zero is never forwarded.
// (RL3) The non-maskable request ranks above all levels and ignores the CPU mask.
// (RL4) The non-maskable pin is edge detected; a control bit picks rising or falling.
// (RL5) Accepting the non-maskable request loads the CPU mask with level 15.
// (RL6) Two sense bits per external pin pick low, falling, rising or both edges.
// (RL7) Low-level mode requests only while the pin is low, without latching.
// (RL8) A readable status flag per external pin shows its present or detected request.
// (RL9) Edge modes raise a request on the chosen transition or on either.
// (RL10) An edge request stays latched until accepted, whatever the pin does.
// (RL11) Writing zero to a flag after reading it one withdraws a latched edge request.
// (RL12) Accepting an external pin request loads the CPU mask with that pin's priority.
// (RL13) Each external pin has its own priority 0 to 15 in the first two registers.
// (RL14) Each peripheral module has a priority 0 to 15 in registers three to five.
// (RL15) Accepting a peripheral request loads the CPU mask with that module's priority.
// (RL16) Every request source presents its own distinct vector number.
// (RL17) Each 16-bit priority register holds four read/write fields at 15:12, 11:8, 7:4, 3:0.
// (RL18) The winner is forwarded only when its level strictly exceeds the CPU mask.
// (RL19) Among equal levels the source with the smaller vector number wins.
// (RL20) Reset sets every pin and peripheral priority to level zero.
// (RL21) Accepting a pin interrupt also clears its latched edge flag.
// (RL22) External and non-maskable pins are synchronised before sampling or edge checks.
package pic_pkg;
	// ---------------------------------------------------------------------
	// Sizes
	// ---------------------------------------------------------------------
	localparam int         PIC_EXT_N  = 8;
	localparam int         PIC_PER_N  = 12;
	localparam int         PIC_SRC_N  = PIC_EXT_N + PIC_PER_N;
	localparam int         PIC_FLD_N  = 4;
	localparam int         PIC_LVL_W  = 4;
	localparam int         PIC_VEC_W  = 8;
	localparam int         PIC_SRC_W  = 5;

	// ---------------------------------------------------------------------
	// Register map, byte offsets within the slave window
	// ---------------------------------------------------------------------
	localparam logic [7:0] PIC_OFS_PRIO_A   = 8'h00;
	localparam logic [7:0] PIC_OFS_PRIO_E   = 8'h10;
	localparam logic [7:0] PIC_OFS_CTRL0    = 8'h14;
	localparam logic [7:0] PIC_OFS_SENSE    = 8'h18;
	localparam logic [7:0] PIC_OFS_STATUS   = 8'h1c;
	localparam int         PIC_NMI_EDGE_BIT = 0;
	localparam int         PIC_NMI_LVL_BIT  = 15;
	localparam int         PIC_HI_LSB       = 8;
	localparam int         PIC_PINLV_LSB    = 8;

	// ---------------------------------------------------------------------
	// Field values and reset values
	// ---------------------------------------------------------------------
	localparam logic [3:0] PIC_LVL_OFF   = 4'h0;
	localparam logic [3:0] PIC_LVL_TOP   = 4'hf;
	localparam logic [1:0] PIC_SENSE_LOW = 2'h0;
	localparam logic [1:0] PIC_SENSE_FAL = 2'h1;
	localparam logic [1:0] PIC_SENSE_RIS = 2'h2;
	localparam logic [2:0] PIC_WARM_DONE = 3'h4;
	localparam logic [2:0] PIC_HSIZE_WORD = 3'h2;
	localparam logic       PIC_HRESP_OKAY = 1'b0;
	localparam logic [7:0] PIC_NMI_VEC   = 8'h0b;

	// Vector per source: index 0..7 external pins, 8..19 peripheral fields C15..E3.
	localparam logic [PIC_SRC_N-1:0][PIC_VEC_W-1:0] PIC_SRC_VEC = {
		8'h68, 8'h67, 8'h65, 8'h64, 8'h66, 8'h60, 8'h5c, 8'h58, 8'h57, 8'h56, 8'h55, 8'h54,
		8'h53, 8'h52, 8'h51, 8'h50, 8'h43, 8'h42, 8'h41, 8'h40};

	// ---------------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------------
	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} pic_ahb_in_s;

	typedef struct packed {
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} pic_ahb_out_s;

	typedef struct packed {
		logic                 irq;
		logic                 irq_nmi;
		logic [PIC_LVL_W-1:0] irq_level;
		logic [PIC_VEC_W-1:0] irq_vector;
		logic                 mask_load;
		logic [PIC_LVL_W-1:0] mask_level;
	} pic_cpu_out_s;

	typedef struct packed {
		pic_ahb_out_s                          ahb;
		logic                                  wr_pend;
		logic [7:0]                            wr_ofs;
		logic [PIC_SRC_N-1:0][PIC_LVL_W-1:0]   prio;
		logic                                  nmi_edge_select;
		logic [PIC_EXT_N-1:0]                  sense_hi;
		logic [PIC_EXT_N-1:0]                  sense_lo;
		logic [PIC_EXT_N-1:0]                  pin_s1;
		logic [PIC_EXT_N-1:0]                  pin_s2;
		logic [PIC_EXT_N-1:0]                  pin_s3;
		logic [PIC_EXT_N-1:0]                  pin_f;
		logic                                  nmi_s1;
		logic                                  nmi_s2;
		logic                                  nmi_s3;
		logic                                  nmi_f;
		logic [2:0]                            warm;
		logic [PIC_EXT_N-1:0]                  flag;
		logic [PIC_EXT_N-1:0]                  seen;
		logic                                  nmi_pend;
		logic [PIC_SRC_W-1:0]                  cur_src;
		pic_cpu_out_s                          cpu;
	} pic_state_s;

	localparam pic_state_s PIC_STATE_RST = '{ahb: '{hrdata: 32'h0, hreadyout: 1'b1, hresp: 1'b0}, default: '0};
endpackage

// *** bench/pic_monitor.sv ***
// Checker for the interrupt controller; it sees only the ports of the top module.
// Assumes one clock, a synchronous active-high reset and a clock enable held high by the bench.
module pic_monitor (
	input wire logic                          sys_clk,
	input wire logic                          srst,
	input wire logic                          ce,
	input wire pic_pkg::pic_ahb_in_s          ahb_in,
	input wire pic_pkg::pic_ahb_out_s         ahb_out,
	input wire logic [pic_pkg::PIC_EXT_N-1:0] ext_request_pins,
	input wire logic                          nmi_pin,
	input wire logic [pic_pkg::PIC_PER_N-1:0] periph_req,
	input wire logic [pic_pkg::PIC_LVL_W-1:0] cpu_mask_level,
	input wire logic                          cpu_accept,
	input wire pic_pkg::pic_cpu_out_s         cpu_out
);
	import pic_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	// -------------------------------------------------------------------------
	// Helpers
	// -------------------------------------------------------------------------
	function automatic logic vec_known(input logic [PIC_VEC_W-1:0] v);
		vec_known = 1'b0;
		for (int i = 0; i < PIC_SRC_N; i++) begin
			if (PIC_SRC_VEC[i] == v) vec_known = 1'b1;
		end
	endfunction
	// -------------------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------------------
	a_zero_blocked: assert property (
		cpu_out.irq && !cpu_out.irq_nmi |-> cpu_out.irq_level != PIC_LVL_OFF) else $error("level zero forwarded");
	a_nmi_top: assert property (
		cpu_out.irq_nmi |-> cpu_out.irq && cpu_out.irq_level == PIC_LVL_TOP && cpu_out.irq_vector == PIC_NMI_VEC)
		else $error("nmi request not at top level");
	a_nmi_held: assert property (
		cpu_out.irq_nmi && !cpu_accept |=> cpu_out.irq_nmi) else $error("nmi request dropped before accept");
	a_above_mask: assert property (
		cpu_out.irq && !cpu_out.irq_nmi && $stable(cpu_mask_level) |-> cpu_out.irq_level > cpu_mask_level)
		else $error("request forwarded at or below mask");
	a_accept_loads: assert property (
		cpu_accept && cpu_out.irq |=> cpu_out.mask_load && !cpu_out.irq && cpu_out.mask_level == $past(cpu_out.irq_level))
		else $error("accept did not load the taken level");
	a_load_cause: assert property (
		cpu_out.mask_load |-> $past(cpu_accept) && $past(cpu_out.irq) ##1 !cpu_out.mask_load)
		else $error("mask load without accept or too long");
	a_vector_known: assert property (
		cpu_out.irq && !cpu_out.irq_nmi |-> vec_known(cpu_out.irq_vector)) else $error("unknown vector presented");
	a_rdata_holds: assert property (
		!(ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready && !ahb_in.hwrite) |=> $stable(ahb_out.hrdata))
		else $error("read data moved without a read");
	a_reset_quiet: assert property (disable iff (1'b0)
		srst |=> !cpu_out.irq && !cpu_out.mask_load && ahb_out.hrdata == 32'h0) else $error("outputs busy in reset");
	c_nmi_taken: cover property (cpu_out.irq_nmi && cpu_accept);
	c_pin_taken: cover property (cpu_accept && cpu_out.irq && cpu_out.irq_vector == PIC_SRC_VEC[5]);
	c_reg_read: cover property (ahb_in.hsel && ahb_in.htrans[1] && !ahb_in.hwrite);
endmodule

bind pic_top pic_monitor u_pic_monitor (.sys_clk(sys_clk), .srst(srst), .ce(ce), .ahb_in(ahb_in),
	.ahb_out(ahb_out), .ext_request_pins(ext_request_pins), .nmi_pin(nmi_pin), .periph_req(periph_req),
	.cpu_mask_level(cpu_mask_level), .cpu_accept(cpu_accept), .cpu_out(cpu_out));

// *** bench/pic_cpu_model.sv ***
// CPU-side partner: takes a presented request after a set wait and keeps the mask level.
// Assumes the controller's registered request outputs on the same clock.
module pic_cpu_model (
	input  wire logic                  sys_clk,
	input  wire logic                  srst,
	input  wire pic_pkg::pic_cpu_out_s cpu_out,
	input  wire logic                  accept_en,
	input  wire logic [3:0]            delay,
	input  wire logic                  set_en,
	input  wire logic [3:0]            set_level,
	output      logic                  cpu_accept,
	output      logic [3:0]            cpu_mask_level
);
	timeunit 1ns;
	timeprecision 1ps;
	import pic_pkg::*;
	logic [3:0] wait_cnt;
	// -------------------------------------------------------------------------
	// Acceptance
	// -------------------------------------------------------------------------
	// The mask rises on the accepting edge, as in the core, so the controller never
	// arbitrates against a stale mask while its own load pulse is still on the way.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cpu_accept     <= 1'b0;
			cpu_mask_level <= 4'h0;
			wait_cnt       <= 4'h0;
		end else begin
			cpu_accept <= 1'b0;
			wait_cnt   <= 4'h0;
			if (set_en) begin
				cpu_mask_level <= set_level;
			end
			if (cpu_out.irq && !cpu_accept && accept_en) begin
				if (wait_cnt >= delay) begin
					cpu_accept     <= 1'b1;
					cpu_mask_level <= cpu_out.irq_level;
				end else begin
					wait_cnt <= wait_cnt + 4'h1;
				end
			end
		end
	end
endmodule

// *** bench/pic_top_tb.sv ***
// Self-checking bench for the interrupt controller: registers over AHB-Lite, pins, NMI and CPU hand-off.
// Assumes the CPU partner model and the bound checker.
module pic_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pic_pkg::*;
	logic                 sys_clk = 1'b0;
	logic                 srst    = 1'b1;
	pic_ahb_in_s          bus     = '0;
	pic_ahb_in_s          ahb_in;
	pic_ahb_out_s         ahb_out;
	logic [PIC_EXT_N-1:0] pins    = '1;
	logic                 nmi     = 1'b1;
	logic [PIC_PER_N-1:0] preq    = '0;
	logic [3:0]           mask;
	logic                 accept;
	pic_cpu_out_s         cpu_out;
	logic                 acc_en  = 1'b0;
	logic                 set_en  = 1'b0;
	logic [3:0]           set_lvl = 4'h0;
	logic [31:0]          rd;
	int                   failures = 0;
	int                   checked  = 0;
	int                   cycles   = 0;
	always #5 sys_clk = ~sys_clk;
	always_comb begin
		ahb_in        = bus;
		ahb_in.hready = ahb_out.hreadyout;
	end
	pic_top u_pic_top (.sys_clk(sys_clk), .srst(srst), .ce(1'b1), .ahb_in(ahb_in), .ahb_out(ahb_out),
		.ext_request_pins(pins), .nmi_pin(nmi), .periph_req(preq), .cpu_mask_level(mask),
		.cpu_accept(accept), .cpu_out(cpu_out));
	pic_cpu_model u_pic_cpu_model (.sys_clk(sys_clk), .srst(srst), .cpu_out(cpu_out), .accept_en(acc_en),
		.delay(4'h2), .set_en(set_en), .set_level(set_lvl), .cpu_accept(accept), .cpu_mask_level(mask));
	// -------------------------------------------------------------------------
	// Tasks
	// -------------------------------------------------------------------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge sys_clk);
		bus.hsel   <= 1'b1;
		bus.haddr  <= {24'h0, a};
		bus.htrans <= 2'b10;
		bus.hwrite <= wr;
		bus.hsize  <= PIC_HSIZE_WORD;
		do @(posedge sys_clk); while (ahb_out.hreadyout !== 1'b1);
		bus.htrans <= 2'b00;
		bus.hwdata <= wd;
		do @(posedge sys_clk); while (ahb_out.hreadyout !== 1'b1);
		rd = ahb_out.hrdata;
	endtask
	task automatic rd_check(input string what, input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		check(what, exp, rd);
		check("response", {31'h0, PIC_HRESP_OKAY}, {31'h0, ahb_out.hresp});
	endtask
	task automatic wait_irq(input string what, input logic [7:0] vec);
		int n;
		n = 0;
		while (cpu_out.irq !== 1'b1 && n < 40) begin
			@(negedge sys_clk);
			n++;
		end
		check(what, {23'h0, 1'b1, vec}, {23'h0, cpu_out.irq, cpu_out.irq_vector});
	endtask
	task automatic wait_load(input logic [3:0] lvl);
		int n;
		n = 0;
		while (cpu_out.mask_load !== 1'b1 && n < 40) begin
			@(negedge sys_clk);
			n++;
		end
		check("mask load", {27'h0, 1'b1, lvl}, {27'h0, cpu_out.mask_load, cpu_out.mask_level});
	endtask
	// -------------------------------------------------------------------------
	// Sequence
	// -------------------------------------------------------------------------
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			give_verdict();
		end
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		srst <= 1'b0;
		for (int r = 0; r < 5; r++) begin
			rd_check("prio reset", PIC_OFS_PRIO_A + 8'(4 * r), 32'h0);
		end
		rd_check("control reset", PIC_OFS_CTRL0, 32'h8000);
		rd_check("status reset", PIC_OFS_STATUS, 32'hff00);
		rd_check("unmapped", 8'h40, 32'h0);
		@(posedge sys_clk);
		preq <= '1;
		repeat (10) @(negedge sys_clk);
		check("zero level request", 32'h0, {31'h0, cpu_out.irq});
		@(posedge sys_clk);
		preq <= '0;
		for (int r = 0; r < 5; r++) begin
			xfer(1'b1, PIC_OFS_PRIO_A + 8'(4 * r), {16'hffff, 4'(r), 4'hf, 4'h0, 4'(15 - r)});
			rd_check("prio field", PIC_OFS_PRIO_A + 8'(4 * r), {16'h0, 4'(r), 4'hf, 4'h0, 4'(15 - r)});
		end
		for (int r = 0; r < 5; r++) begin
			xfer(1'b1, PIC_OFS_PRIO_A + 8'(4 * r), (r == 2) ? 32'h5555 : 32'h0);
		end
		@(posedge sys_clk);
		preq <= 12'h00f;
		wait_irq("tie winner", PIC_SRC_VEC[8]);
		check("periph level", 32'h5, {28'h0, cpu_out.irq_level});
		@(posedge sys_clk);
		acc_en <= 1'b1;
		wait_load(4'h5);
		repeat (4) @(negedge sys_clk);
		check("equal level held", 32'h0, {31'h0, cpu_out.irq});
		xfer(1'b1, PIC_OFS_PRIO_A + 8'h8, 32'h5556);
		wait_irq("above mask", PIC_SRC_VEC[11]);
		wait_load(4'h6);
		@(posedge sys_clk);
		preq    <= '0;
		acc_en  <= 1'b0;
		set_en  <= 1'b1;
		set_lvl <= 4'h0;
		@(posedge sys_clk);
		set_en <= 1'b0;
		xfer(1'b1, PIC_OFS_PRIO_A, 32'h3333);
		for (int m = 0; m < 4; m++) begin
			xfer(1'b1, PIC_OFS_SENSE, (32'(m >> 1) << (8 + m)) | (32'(m & 1) << m));
			@(posedge sys_clk);
			pins[m] <= 1'b0;
			repeat (8) @(negedge sys_clk);
			if (m != 2) wait_irq("pin vector", PIC_SRC_VEC[m]);
			rd_check("flag after fall", PIC_OFS_STATUS, (32'hff00 ^ (32'h100 << m)) | (32'(m != 2) << m));
			@(posedge sys_clk);
			pins[m] <= 1'b1;
			repeat (8) @(negedge sys_clk);
			rd_check("flag after rise", PIC_OFS_STATUS, 32'hff00 | (32'(m != 0) << m));
			xfer(1'b1, PIC_OFS_STATUS, 32'h0);
			rd_check("flag withdrawn", PIC_OFS_STATUS, 32'hff00);
		end
		@(posedge sys_clk);
		pins[3] <= 1'b0;
		repeat (8) @(negedge sys_clk);
		xfer(1'b1, PIC_OFS_STATUS, 32'h0);
		rd_check("unread flag kept", PIC_OFS_STATUS, 32'hf708);
		xfer(1'b1, PIC_OFS_STATUS, 32'h0);
		rd_check("read flag cleared", PIC_OFS_STATUS, 32'hf700);
		xfer(1'b1, PIC_OFS_PRIO_A + 8'h4, 32'h0900);
		xfer(1'b1, PIC_OFS_SENSE, 32'h0828);
		rd_check("sense readback", PIC_OFS_SENSE, 32'h0828);
		@(posedge sys_clk);
		acc_en  <= 1'b1;
		pins[5] <= 1'b0;
		wait_irq("pin five", PIC_SRC_VEC[5]);
		wait_load(4'h9);
		rd_check("flag after accept", PIC_OFS_STATUS, 32'hd700);
		@(posedge sys_clk);
		set_en  <= 1'b1;
		set_lvl <= 4'hf;
		@(posedge sys_clk);
		set_en <= 1'b0;
		xfer(1'b1, PIC_OFS_CTRL0, 32'h1);
		rd_check("edge select", PIC_OFS_CTRL0, 32'h8001);
		@(posedge sys_clk);
		nmi <= 1'b0;
		repeat (12) @(negedge sys_clk);
		check("nmi wrong edge", 32'h0, {31'h0, cpu_out.irq});
		@(posedge sys_clk);
		nmi <= 1'b1;
		wait_irq("nmi rising", PIC_NMI_VEC);
		check("nmi marked", 32'h1, {31'h0, cpu_out.irq_nmi});
		wait_load(4'hf);
		xfer(1'b1, PIC_OFS_CTRL0, 32'h0);
		@(posedge sys_clk);
		nmi <= 1'b0;
		wait_irq("nmi falling", PIC_NMI_VEC);
		wait_load(4'hf);
		give_verdict();
	end
endmodule
